// File: src/mads_datapath.sv
/*
 Add and shift datapath of the 8-bit core: W, status flags, two indirect
 pointers, file register write-back and the extra-cycle stall.
 Assumes the decoder drives the instruction fields and file_rdata_i on the
 same clock, and holds a new instruction until ready_o is high.
*/
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module mads_datapath #(
	parameter int DATA_W = mads_pkg::DATA_W,
	parameter int PTR_W = mads_pkg::PTR_W
) (
	input wire logic clock_i,
	input wire logic rst_i,
	// Instruction issue
	input wire logic instr_valid_i,
	input wire logic [2:0] op_i,
	input wire logic [6:0] f_addr_i,
	input wire logic dest_i,
	input wire logic [7:0] lit_i,
	input wire logic ptr_sel_i,
	input wire logic pc_change_i,
	input wire logic cond_true_i,
	input wire logic [7:0] file_rdata_i,
	output logic ready_o,
	output logic retire_o,
	// File register write-back
	output logic file_we_o,
	output logic [6:0] file_waddr_o,
	output logic [7:0] file_wdata_o,
	// Core state
	output logic [7:0] w_o,
	output logic carry_o,
	output logic digit_carry_flag_o,
	output logic zero_o,
	output logic [15:0] ptr0_o,
	output logic [15:0] ptr1_o,
	// Register port
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o
);
	logic [7:0] w_r;
	logic carry_r;
	logic dc_r;
	logic zero_r;
	logic [15:0] ptr_r [mads_pkg::NUM_PTR];
	logic [1:0] stall_r;
	logic [1:0] stall_nxt;
	logic ready_r;
	logic retire_r;
	logic file_we_r;
	logic [6:0] file_waddr_r;
	logic [7:0] file_wdata_r;
	logic [7:0] rd_data_r;

	logic issue;
	mads_pkg::mads_op_t op;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic ind_hit;
	logic [1:0] extra;
	logic to_file;
	logic to_w;
	logic [15:0] ptr_inc;

	// Ops that read a file register and follow the destination bit
	function automatic logic uses_file(input mads_pkg::mads_op_t o);
		case (o)
			mads_pkg::OP_ADD_REGISTER,
			mads_pkg::OP_AND_REGISTER,
			mads_pkg::OP_ARITH_SHIFT_RIGHT,
			mads_pkg::OP_ADD_REGISTER_WITH_CARRY: uses_file = 1'h1;
			default: uses_file = 1'h0;
		endcase
	endfunction

	// Ops whose result always lands in W
	function automatic logic is_literal(input mads_pkg::mads_op_t o);
		case (o)
			mads_pkg::OP_AND_IMMEDIATE,
			mads_pkg::OP_ADD_IMMEDIATE: is_literal = 1'h1;
			default: is_literal = 1'h0;
		endcase
	endfunction

	assign op = mads_pkg::mads_op_t'(op_i);
	assign issue = instr_valid_i & ready_r;

	mads_alu u_alu (
		.op_i(op_i),
		.w_i(w_r),
		.f_i(file_rdata_i),
		.lit_i(lit_i),
		.carry_i(carry_r),
		.result_o(alu_res),
		.carry_o(alu_c),
		.dc_o(alu_dc),
		.zero_o(alu_z),
		.upd_c_o(upd_c),
		.upd_dc_o(upd_dc),
		.upd_z_o(upd_z)
	);

	// Destination select
	assign to_file = uses_file(op) & dest_i;
	assign to_w = is_literal(op) | (uses_file(op) & ~dest_i);

	// Indirect port access with pointer top bit set
	always_comb begin
		ind_hit = 1'h0;
		if (uses_file(op)) begin
			if (f_addr_i == mads_pkg::IND_PORT0 && ptr_r[0][PTR_W-1]) begin
				ind_hit = 1'h1;
			end
			if (f_addr_i == mads_pkg::IND_PORT1 && ptr_r[1][PTR_W-1]) begin
				ind_hit = 1'h1;
			end
		end
	end

	// Extra cycles run as no-ops after the executing cycle
	always_comb begin
		extra = mads_pkg::NO_EXTRA;
		if (pc_change_i | cond_true_i) begin
			extra = extra + mads_pkg::BRANCH_EXTRA;
		end
		if (ind_hit) begin
			extra = extra + mads_pkg::IND_EXTRA;
		end
	end

	always_comb begin
		stall_nxt = stall_r;
		if (stall_r != 2'h0) begin
			stall_nxt = stall_r - 2'h1;
		end else if (issue) begin
			stall_nxt = extra;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			stall_r <= 2'h0;
			ready_r <= 1'h1;
		end else begin
			stall_r <= stall_nxt;
			ready_r <= (stall_nxt == 2'h0);
		end
	end

	// One pulse when an instruction finishes its last cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			retire_r <= 1'h0;
		end else begin
			retire_r <= (issue && extra == 2'h0) || (stall_r == 2'h1);
		end
	end

	// Working register; the instruction wins over a software write
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			w_r <= mads_pkg::W_RST;
		end else if (issue && to_w) begin
			w_r <= alu_res;
		end else if (reg_wr_i && reg_addr_i == mads_pkg::REG_W) begin
			w_r <= reg_wdata_i;
		end
	end

	// Status flags; a hardware update beats a software write per flag
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			carry_r <= 1'h0;
			dc_r <= 1'h0;
			zero_r <= 1'h0;
		end else begin
			if (reg_wr_i && reg_addr_i == mads_pkg::REG_STATUS) begin
				carry_r <= reg_wdata_i[mads_pkg::ST_C];
				dc_r <= reg_wdata_i[mads_pkg::ST_DC];
				zero_r <= reg_wdata_i[mads_pkg::ST_Z];
			end
			if (issue && upd_c) begin
				carry_r <= alu_c;
			end
			if (issue && upd_dc) begin
				dc_r <= alu_dc;
			end
			if (issue && upd_z) begin
				zero_r <= alu_z;
			end
		end
	end

	// Sign-extended literal; 16-bit sum drops the carry so it wraps
	assign ptr_inc = {{(PTR_W-mads_pkg::LIT6_W){lit_i[5]}}, lit_i[5:0]};

	generate
		for (genvar i = 0; i < mads_pkg::NUM_PTR; i++) begin : g_ptr
			localparam logic [2:0] LO = mads_pkg::REG_P0_LO + 3'(2 * i);
			localparam logic [2:0] HI = mads_pkg::REG_P0_HI + 3'(2 * i);
			logic hit;
			assign hit = issue && op == mads_pkg::OP_ADD_TO_POINTER && ptr_sel_i == 1'(i);
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					ptr_r[i] <= mads_pkg::PTR_RST;
				end else if (hit) begin
					ptr_r[i] <= ptr_r[i] + ptr_inc;
				end else if (reg_wr_i && reg_addr_i == LO) begin
					ptr_r[i][7:0] <= reg_wdata_i;
				end else if (reg_wr_i && reg_addr_i == HI) begin
					ptr_r[i][15:8] <= reg_wdata_i;
				end
			end
		end
	endgenerate

	// File write-back, one cycle after issue
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			file_we_r <= 1'h0;
			file_waddr_r <= 7'h00;
			file_wdata_r <= 8'h00;
		end else begin
			file_we_r <= issue & to_file;
			if (issue && to_file) begin
				file_waddr_r <= f_addr_i;
				file_wdata_r <= alu_res;
			end
		end
	end

	// Register read, data in the following cycle only
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_r <= mads_pkg::RD_RST;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				mads_pkg::REG_W: rd_data_r <= w_r;
				mads_pkg::REG_STATUS: begin
					rd_data_r <= 8'h00;
					rd_data_r[mads_pkg::ST_C] <= carry_r;
					rd_data_r[mads_pkg::ST_DC] <= dc_r;
					rd_data_r[mads_pkg::ST_Z] <= zero_r;
					rd_data_r[mads_pkg::ST_BUSY] <= ~ready_r;
				end
				mads_pkg::REG_P0_LO: rd_data_r <= ptr_r[0][7:0];
				mads_pkg::REG_P0_HI: rd_data_r <= ptr_r[0][15:8];
				mads_pkg::REG_P1_LO: rd_data_r <= ptr_r[1][7:0];
				mads_pkg::REG_P1_HI: rd_data_r <= ptr_r[1][15:8];
				default: rd_data_r <= 8'h00;
			endcase
		end else begin
			rd_data_r <= 8'h00;
		end
	end

	assign ready_o = ready_r;
	assign retire_o = retire_r;
	assign file_we_o = file_we_r;
	assign file_waddr_o = file_waddr_r;
	assign file_wdata_o = file_wdata_r;
	assign w_o = w_r;
	assign carry_o = carry_r;
	assign digit_carry_flag_o = dc_r;
	assign zero_o = zero_r;
	assign ptr0_o = ptr_r[0];
	assign ptr1_o = ptr_r[1];
	assign reg_rdata_o = rd_data_r;
endmodule

// File: src/mads_pkg.sv
/*
 Constants, opcodes and register map of the add and shift datapath.
 Assumes one core clock and a decoder that presents one instruction per issue.
*/
// Operation
// - An instruction that changes the program counter or whose test is true takes two cycles, the second a no-op.
// - Touching an indirect data port whose pointer has its top bit set adds one extra cycle.
// - Add to pointer adds a signed 6-bit literal (-32 to 31) to the 16-bit pointer 0 or 1, flags untouched.
// - Pointer arithmetic wraps modulo 16 bits, never saturates.
// - And immediate ANDs W with an 8-bit literal into W and updates only zero.
// - Add immediate adds an 8-bit literal to W into W and updates carry, digit carry and zero.
// - Add register adds W to file register 0..127, result to W when dest is 0 or to f when 1, updates C, DC, Z.
// - And register ANDs W with file register 0..127, result by dest, updates only zero.
// - Arithmetic shift right moves f bits 7:1 to 6:0, keeps bit 7, bit 0 to carry, updates C and Z, result by dest.
// - Add register with carry sums W, file register and carry, result by dest, updates C, DC, Z.
package mads_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PTR_W = 16;
	localparam int LIT6_W = 6;
	localparam int REG_AW = 3;
	localparam int NUM_PTR = 2;
	localparam int CNT_W = 2;

	// Register map
	localparam logic [2:0] REG_W = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_P0_LO = 3'h2;
	localparam logic [2:0] REG_P0_HI = 3'h3;
	localparam logic [2:0] REG_P1_LO = 3'h4;
	localparam logic [2:0] REG_P1_HI = 3'h5;

	// Status fields
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_BUSY = 3;

	// File addresses that act as indirect data ports
	localparam logic [6:0] IND_PORT0 = 7'h00;
	localparam logic [6:0] IND_PORT1 = 7'h01;

	// Reset values
	localparam logic [7:0] W_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] RD_RST = 8'h00;

	// Cycle counts
	localparam logic [1:0] BRANCH_EXTRA = 2'h1;
	localparam logic [1:0] IND_EXTRA = 2'h1;
	localparam logic [1:0] NO_EXTRA = 2'h0;

	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_ADD_TO_POINTER = 3'b001,
		OP_AND_IMMEDIATE = 3'b010,
		OP_ADD_IMMEDIATE = 3'b011,
		OP_ADD_REGISTER = 3'b100,
		OP_AND_REGISTER = 3'b101,
		OP_ARITH_SHIFT_RIGHT = 3'b110,
		OP_ADD_REGISTER_WITH_CARRY = 3'b111
	} mads_op_t;
endpackage

// File: src/mads_alu.sv
/*
 Combinational byte ALU: adds, ANDs and arithmetic shift with flag results.
 Selects the operand from op_i; assumes the caller applies the update enables.
*/
`timescale 1ns/10ps
module mads_alu (
	input wire logic [2:0] op_i,
	input wire logic [7:0] w_i,
	input wire logic [7:0] f_i,
	input wire logic [7:0] lit_i,
	input wire logic carry_i,
	output logic [7:0] result_o,
	output logic carry_o,
	output logic dc_o,
	output logic zero_o,
	output logic upd_c_o,
	output logic upd_dc_o,
	output logic upd_z_o
);
	logic [7:0] opnd;
	logic cin;
	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		opnd = f_i;
		cin = 1'h0;
		case (mads_pkg::mads_op_t'(op_i))
			mads_pkg::OP_AND_IMMEDIATE,
			mads_pkg::OP_ADD_IMMEDIATE: opnd = lit_i;
			mads_pkg::OP_ADD_REGISTER_WITH_CARRY: cin = carry_i;
			default: opnd = f_i;
		endcase
	end

	assign sum = {1'h0, w_i} + {1'h0, opnd} + {8'h00, cin};
	assign nib = {1'h0, w_i[3:0]} + {1'h0, opnd[3:0]} + {4'h0, cin};

	always_comb begin
		result_o = sum[7:0];
		carry_o = sum[8];
		dc_o = nib[4];
		upd_c_o = 1'h0;
		upd_dc_o = 1'h0;
		upd_z_o = 1'h0;
		case (mads_pkg::mads_op_t'(op_i))
			mads_pkg::OP_ADD_IMMEDIATE,
			mads_pkg::OP_ADD_REGISTER,
			mads_pkg::OP_ADD_REGISTER_WITH_CARRY: begin
				upd_c_o = 1'h1;
				upd_dc_o = 1'h1;
				upd_z_o = 1'h1;
			end
			mads_pkg::OP_AND_IMMEDIATE,
			mads_pkg::OP_AND_REGISTER: begin
				result_o = w_i & opnd;
				upd_z_o = 1'h1;
			end
			mads_pkg::OP_ARITH_SHIFT_RIGHT: begin
				result_o = {f_i[7], f_i[7:1]};
				carry_o = f_i[0];
				upd_c_o = 1'h1;
				upd_z_o = 1'h1;
			end
			default: result_o = sum[7:0];
		endcase
		zero_o = (result_o == 8'h00);
	end
endmodule

// File: verification/mads_datapath_asserts.sv
/*
 Port checker for the add and shift datapath.
 Assumes a bind from the test top; one clock, asynchronous reset.
*/
`timescale 1ns/10ps
module mads_datapath_asserts (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [2:0] op_i,
	input wire logic [6:0] f_addr_i,
	input wire logic dest_i,
	input wire logic [7:0] lit_i,
	input wire logic ptr_sel_i,
	input wire logic pc_change_i,
	input wire logic cond_true_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic reg_wr_i,
	input wire logic ready_o,
	input wire logic file_we_o,
	input wire logic [6:0] file_waddr_o,
	input wire logic [7:0] file_wdata_o,
	input wire logic [7:0] w_o,
	input wire logic carry_o,
	input wire logic digit_carry_flag_o,
	input wire logic zero_o,
	input wire logic [15:0] ptr1_o
);
	logic iss;
	assign iss = instr_valid_i && ready_o;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_pc_stall: assert property (iss && (pc_change_i || cond_true_i) && !op_i[2] |=> !ready_o ##1 ready_o)
		else $error("branch stall length wrong");
	a_ind_stall: assert property (iss && !pc_change_i && !cond_true_i && op_i[2] && f_addr_i == 7'h01 && ptr1_o[15]
		|=> !ready_o ##1 ready_o) else $error("indirect stall length wrong");
	a_ptr_flags: assert property (iss && op_i == 3'h1 && !reg_wr_i |=> $stable({carry_o, digit_carry_flag_o, zero_o}))
		else $error("pointer add touched flags");
	a_ptr_wrap: assert property (iss && op_i == 3'h1 && ptr_sel_i && !reg_wr_i
		|=> ptr1_o == $past(ptr1_o) + {{10{$past(lit_i[5])}}, $past(lit_i[5:0])}) else $error("pointer sum wrong");
	a_andi_zero: assert property (iss && op_i == 3'h2 && !reg_wr_i
		|=> w_o == ($past(w_o) & $past(lit_i)) && zero_o == (w_o == 8'h00) && $stable(carry_o))
		else $error("and immediate result wrong");
	a_addi_sum: assert property (iss && op_i == 3'h3 && !reg_wr_i |=> {carry_o, w_o} == $past(w_o) + $past(lit_i)
		&& digit_carry_flag_o == (5'($past(w_o[3:0])) + 5'($past(lit_i[3:0])) > 5'h0f)) else $error("add immediate wrong");
	a_file_dest: assert property (iss && op_i[2] |=> file_we_o == $past(dest_i)
		&& (!file_we_o || file_waddr_o == $past(f_addr_i))) else $error("file write-back wrong");
	a_shift_bits: assert property (iss && op_i == 3'h6 && !reg_wr_i |=> carry_o == $past(file_rdata_i[0])
		&& (!file_we_o || file_wdata_o == {$past(file_rdata_i[7]), $past(file_rdata_i[7:1])})) else $error("shift wrong");
	a_addc_sum: assert property (iss && op_i == 3'h7 && !dest_i && !reg_wr_i
		|=> {carry_o, w_o} == $past(w_o) + $past(file_rdata_i) + $past(carry_o) && zero_o == (w_o == 8'h00))
		else $error("add with carry wrong");
endmodule

// File: verification/mads_datapath_test.sv
/*
 Self-checking test of mads_datapath through its issue and register ports.
 Assumes the checker module is compiled before this file.
*/
`timescale 1ns/10ps
module mads_datapath_test;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0, dest_i = 1'b0, ptr_sel_i = 1'b0, pc_change_i = 1'b0, cond_true_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [2:0] op_i = 3'h0, reg_addr_i = 3'h0;
	logic [6:0] f_addr_i = 7'h00, file_waddr_o;
	logic [7:0] lit_i = 8'h00, file_rdata_i = 8'h00, reg_wdata_i = 8'h00, file_wdata_o, w_o, reg_rdata_o;
	logic ready_o, retire_o, file_we_o, carry_o, digit_carry_flag_o, zero_o, we_s, rt0_s, rt_s;
	logic [15:0] ptr0_o, ptr1_o;
	int n_mismatch = 0, n_compared = 0, stall = 0, cyc = 0;

	always #4 clock_i = ~clock_i;
	mads_datapath u_mads_datapath (.*);

	task automatic conclude();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cw(input logic [7:0] ew, input logic [2:0] ef);
		chk("w", {8'h00, ew}, {8'h00, w_o});
		chk("flags_c_dc_z", {13'h0000, ef}, {13'h0000, carry_o, digit_carry_flag_o, zero_o});
	endtask
	task automatic issue(input logic [2:0] op, input logic [6:0] fa, input logic d, input logic [7:0] lit,
		input logic [7:0] fr, input logic ps, input logic [1:0] br);
		instr_valid_i <= 1'b1;
		op_i <= op;
		f_addr_i <= fa;
		dest_i <= d;
		lit_i <= lit;
		file_rdata_i <= fr;
		ptr_sel_i <= ps;
		{cond_true_i, pc_change_i} <= br;
		@(posedge clock_i);
		instr_valid_i <= 1'b0;
		#1;
		we_s = file_we_o;
		rt0_s = retire_o;
		stall = 0;
		// Bounded so a stuck ready cannot hang here
		while (!ready_o && stall < 4) begin
			@(posedge clock_i);
			#1;
			stall++;
		end
		rt_s = retire_o;
	endtask
	task automatic regw(input logic [2:0] a, input logic [7:0] v);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic regr(input logic [2:0] a, input logic [7:0] e);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata_o});
	endtask

	always @(posedge clock_i) begin
		cyc++;
		if (cyc > 2000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		regw(3'h0, 8'h0a);
		issue(3'h3, 7'h00, 1'b0, 8'h05, 8'h00, 1'b0, 2'h0);
		cw(8'h0f, 3'b000);
		issue(3'h3, 7'h00, 1'b0, 8'hf1, 8'h00, 1'b0, 2'h0);
		cw(8'h00, 3'b111);
		regw(3'h0, 8'hf0);
		issue(3'h2, 7'h00, 1'b0, 8'h3c, 8'h00, 1'b0, 2'h0);
		cw(8'h30, 3'b110);
		issue(3'h2, 7'h00, 1'b0, 8'h0f, 8'h00, 1'b0, 2'h0);
		cw(8'h00, 3'b111);
		regw(3'h0, 8'h30);
		issue(3'h4, 7'h05, 1'b1, 8'h00, 8'h80, 1'b0, 2'h0);
		chk("file_we", 16'h0001, {15'h0000, we_s});
		chk("file_wdata", 16'h00b0, {8'h00, file_wdata_o});
		chk("file_waddr", 16'h0005, {9'h000, file_waddr_o});
		cw(8'h30, 3'b000);
		issue(3'h5, 7'h06, 1'b0, 8'h00, 8'h0f, 1'b0, 2'h0);
		chk("file_we", 16'h0000, {15'h0000, we_s});
		cw(8'h00, 3'b001);
		issue(3'h6, 7'h09, 1'b1, 8'h00, 8'h81, 1'b0, 2'h0);
		chk("file_wdata", 16'h00c0, {8'h00, file_wdata_o});
		cw(8'h00, 3'b100);
		issue(3'h6, 7'h09, 1'b0, 8'h00, 8'h02, 1'b0, 2'h0);
		cw(8'h01, 3'b000);
		regw(3'h1, 8'h01);
		regw(3'h0, 8'h0f);
		issue(3'h7, 7'h03, 1'b0, 8'h00, 8'h01, 1'b0, 2'h0);
		cw(8'h11, 3'b010);
		issue(3'h7, 7'h03, 1'b0, 8'h00, 8'hef, 1'b0, 2'h0);
		cw(8'h00, 3'b111);
		regw(3'h2, 8'hfe);
		regw(3'h3, 8'hff);
		issue(3'h1, 7'h00, 1'b0, 8'h03, 8'h00, 1'b0, 2'h0);
		chk("ptr0", 16'h0001, ptr0_o);
		issue(3'h1, 7'h00, 1'b0, 8'h20, 8'h00, 1'b1, 2'h0);
		chk("ptr1", 16'hffe0, ptr1_o);
		cw(8'h00, 3'b111);
		issue(3'h5, 7'h01, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0);
		chk("stall", 16'h0001, stall[15:0]);
		issue(3'h5, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0);
		chk("stall", 16'h0000, stall[15:0]);
		chk("retire", 16'h0001, {15'h0000, rt0_s});
		issue(3'h5, 7'h01, 1'b0, 8'h00, 8'h00, 1'b0, 2'h1);
		chk("stall", 16'h0002, stall[15:0]);
		chk("retire_early", 16'h0000, {15'h0000, rt0_s});
		chk("retire", 16'h0001, {15'h0000, rt_s});
		issue(3'h0, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 2'h2);
		chk("stall", 16'h0001, stall[15:0]);
		issue(3'h2, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 2'h1);
		chk("stall", 16'h0001, stall[15:0]);
		regr(3'h5, 8'hff);
		regr(3'h6, 8'h00);
		regr(3'h1, 8'h07);
		regr(3'h0, 8'h00);
		conclude();
	end
endmodule

bind mads_datapath mads_datapath_asserts u_mads_datapath_asserts (.*);
